// ### vic_pkg.sv
// Package with constants for the vectored interrupt controller.
package vic_pkg;
  // ==========================================================================
  // Source indices and arbitration ranks.
  localparam int unsigned NUM_SRC   = 8;
  localparam logic [2:0]  SRC_RST   = 3'h0;
  localparam logic [2:0]  SRC_NMI   = 3'h1;
  localparam logic [2:0]  SRC_E2    = 3'h2;
  localparam logic [2:0]  SRC_E3    = 3'h3;
  localparam logic [2:0]  SRC_E4    = 3'h4;
  localparam logic [2:0]  SRC_TMR   = 3'h5;
  localparam logic [2:0]  SRC_SER   = 3'h6;
  localparam logic [2:0]  SRC_HI    = 3'h7;
  // ==========================================================================
  // Vector addresses (low word of each pair).
  localparam logic [15:0] VEC_RST   = 16'hFFFE;
  localparam logic [15:0] VEC_NMI   = 16'hFFFC;
  localparam logic [15:0] VEC_E2    = 16'hFFFA;
  localparam logic [15:0] VEC_E3    = 16'hFFF8;
  localparam logic [15:0] VEC_E4    = 16'hFFF6;
  localparam logic [15:0] VEC_TMR   = 16'hFFF4;
  localparam logic [15:0] VEC_SER   = 16'hFFF2;
  localparam logic [15:0] VEC_HI    = 16'hFFF0;
  // ==========================================================================
  // Reset values and stack step.
  localparam logic [7:0]  PEND_RST  = 8'h00;
  localparam logic [7:0]  ENAB_RST  = 8'h00;
  localparam logic [2:0]  POL_RST   = 3'h0;
  localparam logic [15:0] SP_STEP   = 16'h0002;
  localparam logic [15:0] SP_RST    = 16'h0000;
  localparam logic [15:0] PC_RST    = 16'h0000;
  // ==========================================================================
  // Power states.
  typedef enum logic [1:0] {
    VIC_RUN  = 2'b00,
    VIC_IDLE = 2'b01,
    VIC_HALT = 2'b10
  } vic_pwr_t;
endpackage : vic_pkg

// ### vic_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
`default_nettype none
module vic_sync (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic pinIn,
  output logic      pinOut
);
  logic stage1;
  logic stage2;
  logic stage3;

  // ==========================================================================
  // Stage one is read only by stage two.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pinOut <= 1'b0;
    end else if (stage2 == stage3) begin
      pinOut <= stage3;
    end
  end
endmodule : vic_sync
`default_nettype wire

// ### vic_ctrl.sv
// Vectored interrupt controller with pending, enable and power-save logic.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Edge pins two to four own vectors.
// - Lowest rank number wins simultaneous requests.
// - Timer overflow requests rank five; free timer overflow does not.
// - Serial done or low pin: rank six.
// - High-level pin ranks last, lowest vector.
// - Interrupts wait for instruction end; reset immediate.
// - Reset, shared pin low; high pin level.
// - Others edge; nonmaskable on rising edge.
// - Polarity bits select edge pins' edge.
// - Reset, nonmaskable unmaskable; others individually enabled.
// - Maskable needs own and global enable.
// - Pending flags set regardless of enable.
// - Hardware clears nonmaskable and edge pin flags on service.
// - Nonmaskable flag read-only; edge flags write-zero-clear.
// - Idle exits on reset, nonmaskable, free timer.
// - Halt exits only on reset or nonmaskable.
// - Halt enable writable only once.
// - Acknowledge pushes, saves enable, clears it, vectors.
// - Restoring return re-enables if saved enable set.
module vic_ctrl
  import vic_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        reset_n_pin,
  input  wire logic        nonmaskable_pin,
  input  wire logic        edge_pin_two,
  input  wire logic        edge_pin_three,
  input  wire logic        edge_pin_four,
  input  wire logic        shared_low_level_irq_pin,
  input  wire logic        high_level_irq_pin,
  input  wire logic        timerOverflow,
  input  wire logic        freeTimerOverflow,
  input  wire logic        serialRxDone,
  input  wire logic        serialTxDone,
  input  wire logic        serial_rx_irq_enable,
  input  wire logic        serial_tx_irq_enable,
  input  wire logic        instrDone,
  input  wire logic        return_restore_enable,
  input  wire logic        plainReturn,
  input  wire logic        enableWrite,
  input  wire logic [7:0]  enableWrData,
  input  wire logic        pendWrite,
  input  wire logic [7:0]  pendWrData,
  input  wire logic        condWrite,
  input  wire logic [2:0]  condWrData,
  input  wire logic        haltEnWrite,
  input  wire logic        haltEnWrData,
  input  wire logic        idleRequest,
  input  wire logic        haltRequest,
  input  wire logic [15:0] stackPopData,
  output logic [7:0]       irq_enable_reg,
  output logic [7:0]       irq_pending_reg,
  output logic [2:0]       irq_condition_reg,
  output logic             global_irq_enable,
  output logic             saved_global_enable,
  output logic             haltEnable,
  output logic             haltEnLocked,
  output logic [1:0]       powerState,
  output logic             coreReset,
  output logic             intAck,
  output logic [2:0]       ackSource,
  output logic [15:0]      vectorAddr,
  output logic [15:0]      programCounter,
  output logic [15:0]      stackPointer,
  output logic [15:0]      pushData,
  output logic             pushStrobe
);
  // ==========================================================================
  // Pin synchronisers.
  logic [5:0] pinRaw;
  logic [5:0] pinSync;
  // The low pin is inverted ahead of its synchroniser so that the reset value
  // matches its idle level and no false request follows reset.
  assign pinRaw = {high_level_irq_pin, ~shared_low_level_irq_pin,
                   edge_pin_four, edge_pin_three, edge_pin_two,
                   nonmaskable_pin};

  for (genvar g = 0; g < 6; g++) begin : gSync
    vic_sync uSync (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .pinIn   (pinRaw[g]),
      .pinOut  (pinSync[g])
    );
  end

  logic       nmiLvl;
  logic [2:0] edgeLvl;
  logic       lowLvl;
  logic       hiLvl;
  logic       resetReq;
  logic       resetSyncA;
  logic       resetSyncB;
  logic       resetSyncC;
  assign nmiLvl  = pinSync[0];
  assign edgeLvl = pinSync[3:1];
  assign lowLvl  = pinSync[4];
  assign hiLvl   = pinSync[5];

  // ==========================================================================
  // Reset pin is an active-low level request.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      resetSyncA <= 1'b1;
      resetSyncB <= 1'b1;
      resetSyncC <= 1'b1;
      resetReq   <= 1'b0;
    end else begin
      resetSyncA <= reset_n_pin;
      resetSyncB <= resetSyncA;
      resetSyncC <= resetSyncB;
      if (resetSyncB == resetSyncC) begin
        resetReq <= ~resetSyncC;
      end
    end
  end

  // ==========================================================================
  // Edge detection.
  logic       nmiPrev;
  logic [2:0] edgePrev;
  logic       nmiEvent;
  logic [2:0] edgeEvent;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      nmiPrev  <= 1'b0;
      edgePrev <= 3'h0;
    end else begin
      nmiPrev  <= nmiLvl;
      edgePrev <= edgeLvl;
    end
  end

  assign nmiEvent = nmiLvl & ~nmiPrev;
  // Polarity bit high selects a rising edge, low a falling edge.
  assign edgeEvent = (irq_condition_reg & edgeLvl & ~edgePrev)
                   | (~irq_condition_reg & ~edgeLvl & edgePrev);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_condition_reg <= POL_RST;
    end else if (condWrite) begin
      irq_condition_reg <= condWrData;
    end
  end

  // ==========================================================================
  // Level-sensed requests.
  logic serialReq;
  logic serialEnable;
  // The low pin is OR'ed with serial completion; a floating pin must read high.
  assign serialReq = lowLvl
                   | (serialRxDone & serial_rx_irq_enable)
                   | (serialTxDone & serial_tx_irq_enable);
  assign serialEnable = irq_enable_reg[SRC_SER];

  // ==========================================================================
  // Enable register; bit 0 is the global enable.
  logic ackNow;
  logic [2:0] winner;

  always_ff @(posedge sys_clk) begin
    if (sys_rst || resetReq) begin
      irq_enable_reg[7:1] <= ENAB_RST[7:1];
    end else if (enableWrite) begin
      irq_enable_reg[7:1] <= enableWrData[7:1];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || resetReq) begin
      global_irq_enable   <= 1'b0;
      saved_global_enable <= 1'b0;
    end else if (ackNow) begin
      saved_global_enable <= global_irq_enable;
      global_irq_enable   <= 1'b0;
    end else if (return_restore_enable && saved_global_enable) begin
      global_irq_enable <= 1'b1;
    end else if (enableWrite) begin
      global_irq_enable <= enableWrData[0];
    end
  end
  assign irq_enable_reg[0] = global_irq_enable;

  // ==========================================================================
  // Pending flags: hardware sets win over every clear.
  logic [7:0] setPend;
  logic [7:0] clrPend;

  always_comb begin
    setPend          = 8'h00;
    setPend[SRC_NMI] = nmiEvent;
    setPend[SRC_E2]  = edgeEvent[0];
    setPend[SRC_E3]  = edgeEvent[1];
    setPend[SRC_E4]  = edgeEvent[2];
    setPend[SRC_TMR] = timerOverflow;
    setPend[SRC_SER] = serialReq;
    setPend[SRC_HI]  = hiLvl;
    clrPend = 8'h00;
    if (pendWrite) begin
      clrPend[SRC_E2]  = ~pendWrData[SRC_E2];
      clrPend[SRC_E3]  = ~pendWrData[SRC_E3];
      clrPend[SRC_E4]  = ~pendWrData[SRC_E4];
      clrPend[SRC_TMR] = ~pendWrData[SRC_TMR];
    end
    if (ackNow) begin
      case (winner)
        SRC_NMI, SRC_E2, SRC_E3, SRC_E4: begin
          clrPend[winner] = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // Level sources track their input; they cannot be latched or written.
  always_ff @(posedge sys_clk) begin
    if (sys_rst || resetReq) begin
      irq_pending_reg <= PEND_RST;
    end else begin
      irq_pending_reg[5:0] <= (irq_pending_reg[5:0] & ~clrPend[5:0])
                            | setPend[5:0];
      irq_pending_reg[7:6] <= setPend[7:6];
    end
  end

  // ==========================================================================
  // Arbitration: lowest rank number first.
  logic [7:0] eligible;
  logic       anyReq;
  always_comb begin
    eligible          = irq_pending_reg & irq_enable_reg
                      & {8{global_irq_enable}};
    eligible[SRC_RST] = 1'b0;
    eligible[SRC_NMI] = irq_pending_reg[SRC_NMI];
    if (!serialEnable) begin
      eligible[SRC_SER] = 1'b0;
    end
    winner = SRC_HI;
    anyReq = 1'b0;
    for (int i = NUM_SRC - 1; i >= 1; i--) begin
      if (eligible[i]) begin
        winner = 3'(i);
        anyReq = 1'b1;
      end
    end
  end

  function automatic logic [15:0] vecOf(input logic [2:0] src);
    case (src)
      SRC_RST: vecOf = VEC_RST;
      SRC_NMI: vecOf = VEC_NMI;
      SRC_E2:  vecOf = VEC_E2;
      SRC_E3:  vecOf = VEC_E3;
      SRC_E4:  vecOf = VEC_E4;
      SRC_TMR: vecOf = VEC_TMR;
      SRC_SER: vecOf = VEC_SER;
      SRC_HI:  vecOf = VEC_HI;
      default: vecOf = VEC_RST;
    endcase
  endfunction : vecOf

  // ==========================================================================
  // Power state and halt-enable lock.
  vic_pwr_t pwr;
  logic     wakeIdle;
  logic     wakeHalt;
  assign wakeIdle = nmiEvent | freeTimerOverflow;
  assign wakeHalt = nmiEvent;
  assign powerState = pwr;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      haltEnable   <= 1'b0;
      haltEnLocked <= 1'b0;
    end else if (haltEnWrite && !haltEnLocked) begin
      haltEnable   <= haltEnWrData;
      haltEnLocked <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || resetReq) begin
      pwr <= VIC_RUN;
    end else begin
      case (pwr)
        VIC_RUN: begin
          if (haltRequest && haltEnable) begin
            pwr <= VIC_HALT;
          end else if (idleRequest) begin
            pwr <= VIC_IDLE;
          end
        end
        VIC_IDLE: begin
          if (wakeIdle) begin
            pwr <= VIC_RUN;
          end
        end
        VIC_HALT: begin
          if (wakeHalt) begin
            pwr <= VIC_RUN;
          end
        end
        default: pwr <= VIC_RUN;
      endcase
    end
  end

  // ==========================================================================
  // Acknowledge at instruction boundary; reset acts at once.
  assign ackNow = instrDone && anyReq && (pwr == VIC_RUN);
  assign coreReset = resetReq;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      intAck         <= 1'b0;
      ackSource      <= SRC_RST;
      vectorAddr     <= VEC_RST;
      programCounter <= PC_RST;
      stackPointer   <= SP_RST;
      pushData       <= 16'h0000;
      pushStrobe     <= 1'b0;
    end else if (resetReq) begin
      intAck         <= 1'b1;
      ackSource      <= SRC_RST;
      vectorAddr     <= VEC_RST;
      programCounter <= VEC_RST;
      stackPointer   <= SP_RST;
      pushStrobe     <= 1'b0;
    end else if (ackNow) begin
      intAck         <= 1'b1;
      ackSource      <= winner;
      vectorAddr     <= vecOf(winner);
      pushData       <= programCounter;
      pushStrobe     <= 1'b1;
      stackPointer   <= stackPointer + SP_STEP;
      programCounter <= vecOf(winner);
    end else begin
      intAck     <= 1'b0;
      pushStrobe <= 1'b0;
      if (return_restore_enable || plainReturn) begin
        stackPointer   <= stackPointer - SP_STEP;
        programCounter <= stackPopData;
      end
    end
  end
endmodule : vic_ctrl
`default_nettype wire

// ### vic_ctrl_sva.sv
// Assertion checker bound to the interrupt controller ports.
`timescale 1ns/1ps
`default_nettype none
module vic_ctrl_sva
  import vic_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        instrDone,
  input wire logic        pendWrite,
  input wire logic [7:0]  pendWrData,
  input wire logic        haltEnWrite,
  input wire logic [7:0]  irq_enable_reg,
  input wire logic [7:0]  irq_pending_reg,
  input wire logic        global_irq_enable,
  input wire logic        saved_global_enable,
  input wire logic        haltEnable,
  input wire logic        haltEnLocked,
  input wire logic        coreReset,
  input wire logic        intAck,
  input wire logic [2:0]  ackSource,
  input wire logic [15:0] vectorAddr,
  input wire logic [15:0] programCounter,
  input wire logic [15:0] stackPointer,
  input wire logic        pushStrobe
);
  // ==========================================================================
  // Helpers.
  // Reset vectoring raises intAck with the reset source, also for one cycle
  // after coreReset falls, so it is kept apart from real service.
  wire logic       ack = intAck && ackSource != SRC_RST;
  wire logic [7:0] elig = irq_pending_reg &
    {irq_enable_reg[7:2] & {6{global_irq_enable}}, 2'b11};
  wire logic [7:0] below = (8'h01 << ackSource) - 8'h01;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================================
  // Assertions.
  a_ack_at_boundary: assert property (
    ack |-> $past(instrDone))
    else $error("service taken without instruction boundary");
  a_ack_vector_map: assert property (
    ack |-> vectorAddr == 16'hfffe - {12'h000, ackSource, 1'b0})
    else $error("vector does not match source");
  a_ack_loads_pc: assert property (
    ack |-> programCounter == vectorAddr && pushStrobe)
    else $error("program counter not loaded from vector");
  a_ack_stack_push: assert property (
    ack |-> stackPointer == $past(stackPointer) + SP_STEP)
    else $error("stack pointer not raised by two");
  a_ack_saves_enable: assert property (
    ack |-> !global_irq_enable && saved_global_enable == $past(global_irq_enable))
    else $error("global enable not saved and cleared");
  a_mask_gate: assert property (
    ack && ackSource > SRC_NMI |->
      ($past(elig) & (8'h01 << ackSource)) != 8'h00)
    else $error("masked source serviced");
  a_lowest_rank: assert property (
    ack |-> ($past(elig) & below) == 8'h00)
    else $error("higher ranked request passed over");
  a_nmi_read_only: assert property (
    pendWrite && !pendWrData[1] && irq_pending_reg[1] && !instrDone
      |=> irq_pending_reg[1])
    else $error("nonmaskable flag cleared by write");
  a_write_one_keeps: assert property (
    pendWrite && pendWrData[4:2] == 3'h7 && !instrDone |=>
      (irq_pending_reg[4:2] & $past(irq_pending_reg[4:2]))
        == $past(irq_pending_reg[4:2]))
    else $error("edge flag changed by writing one");
  a_halt_once: assert property (
    haltEnLocked && haltEnWrite && !coreReset |=> $stable(haltEnable))
    else $error("halt enable changed after lock");
  c_nmi: cover property (ack && ackSource == SRC_NMI);
  c_high: cover property (ack && ackSource == SRC_HI);
  c_locked: cover property (haltEnLocked && haltEnWrite);
endmodule : vic_ctrl_sva
bind vic_ctrl vic_ctrl_sva u_sva (.sys_clk, .sys_rst, .instrDone, .pendWrite,
  .pendWrData, .haltEnWrite, .irq_enable_reg, .irq_pending_reg,
  .global_irq_enable, .saved_global_enable, .haltEnable, .haltEnLocked,
  .coreReset, .intAck, .ackSource, .vectorAddr, .programCounter,
  .stackPointer, .pushStrobe);
`default_nettype wire

// ### vic_core_model.sv
// Behavioural model of the core sequencer that faces the controller.
`timescale 1ns/1ps
`default_nettype none
module vic_core_model (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        slow,
  input  wire logic        intAck,
  input  wire logic        coreReset,
  input  wire logic        pushStrobe,
  input  wire logic [15:0] pushData,
  output logic             instrDone,
  output logic             return_restore_enable,
  output logic [15:0]      stackPopData
);
  // ==========================================================================
  // Sequencer.
  logic [15:0] stk;
  logic [3:0]  cnt;
  logic [3:0]  retCnt;
  // A return is itself an instruction, so it never shares a boundary pulse.
  always_ff @(negedge sys_clk) begin
    if (sys_rst || coreReset) begin
      cnt <= 4'h0;
      retCnt <= 4'h0;
      instrDone <= 1'b0;
      return_restore_enable <= 1'b0;
      stackPopData <= 16'h0000;
    end else begin
      cnt <= cnt + 4'h1;
      instrDone <= (!slow || cnt[1:0] == 2'b11) && retCnt != 4'h1;
      if (pushStrobe) stk <= pushData;
      // Only a real service, marked by its push, starts a return.
      retCnt <= pushStrobe ? 4'h6 : (retCnt != 4'h0 ? retCnt - 4'h1 : 4'h0);
      return_restore_enable <= retCnt == 4'h1;
      // Outside a return the pop bus shows junk, not the last value.
      stackPopData <= retCnt == 4'h1 ? stk : ~stk;
    end
  end
endmodule : vic_core_model
`default_nettype wire

// ### vic_ctrl_tb_top.sv
// Self-checking testbench for the interrupt controller.
`timescale 1ns/1ps
`default_nettype none
module vic_ctrl_tb_top
  import vic_pkg::*;
;
  logic sys_clk = 1'b0;
  logic sys_rst, reset_n_pin, nonmaskable_pin, shared_low_level_irq_pin;
  logic high_level_irq_pin, timerOverflow, freeTimerOverflow, slow;
  logic serialRxDone, serial_rx_irq_enable, enableWrite, pendWrite;
  logic condWrite, haltEnWrite, haltEnWrData, idleRequest, haltRequest;
  logic instrDone, return_restore_enable, pushStrobe, coreReset, intAck;
  logic global_irq_enable, haltEnable;
  logic plainReturn, serialTxDone, serial_tx_irq_enable;
  logic [2:0]  ep, condWrData, ackSource, pol;
  logic [7:0]  enableWrData, pendWrData, irq_enable_reg, irq_pending_reg;
  logic [1:0]  powerState;
  logic [15:0] stackPopData, vectorAddr, programCounter, pushData;
  logic [15:0] stackPointer;
  logic [2:0]  acks[$];
  int fails = 0, num_checks = 0, cycles = 0, i;
  always #12.5 sys_clk = ~sys_clk;
  vic_ctrl uut (.sys_clk, .sys_rst, .reset_n_pin, .nonmaskable_pin,
    .edge_pin_two(ep[0]), .edge_pin_three(ep[1]), .edge_pin_four(ep[2]),
    .shared_low_level_irq_pin, .high_level_irq_pin, .timerOverflow,
    .freeTimerOverflow, .serialRxDone, .serialTxDone,
    .serial_rx_irq_enable, .serial_tx_irq_enable, .instrDone,
    .return_restore_enable, .plainReturn, .enableWrite, .enableWrData,
    .pendWrite, .pendWrData, .condWrite, .condWrData, .haltEnWrite,
    .haltEnWrData, .idleRequest, .haltRequest, .stackPopData,
    .irq_enable_reg, .irq_pending_reg, .irq_condition_reg(),
    .global_irq_enable, .saved_global_enable(), .haltEnable,
    .haltEnLocked(), .powerState, .coreReset, .intAck, .ackSource,
    .vectorAddr, .programCounter, .stackPointer, .pushData, .pushStrobe);
  vic_core_model core (.sys_clk, .sys_rst, .slow, .intAck, .coreReset,
    .pushStrobe, .pushData, .instrDone, .return_restore_enable,
    .stackPopData);
  // ==========================================================================
  // Tasks.
  function automatic logic [15:0] vecOf(input logic [2:0] s);
    return 16'hfffe - {12'h000, s, 1'b0};
  endfunction : vecOf
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask : pulse
  task automatic wen(input logic [7:0] d);
    enableWrData = d;
    pulse(enableWrite);
  endtask : wen
  task automatic wpend(input logic [7:0] d);
    pendWrData = d;
    pulse(pendWrite);
  endtask : wpend
  task automatic expAck(input logic [2:0] s);
    for (int k = 0; k < 60 && acks.size() == 0; k++) cyc(1);
    chk(acks.size() ? {13'h0000, acks.pop_front()} : 16'hffff,
        {13'h0000, s});
  endtask : expAck
  task automatic stop_test;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  // ==========================================================================
  // Monitors.
  always @(negedge sys_clk) begin
    if (intAck === 1'b1 && ackSource !== SRC_RST) begin
      acks.push_back(ackSource);
      chk(vectorAddr, vecOf(ackSource));
      chk(programCounter, vecOf(ackSource));
    end
  end
  // The whole run needs a few hundred cycles; this ceiling cuts a hang.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end
  // ==========================================================================
  // Main sequence.
  initial begin
    {nonmaskable_pin, ep, high_level_irq_pin, timerOverflow, slow} = '0;
    {freeTimerOverflow, serialRxDone, serial_rx_irq_enable} = '0;
    {plainReturn, serialTxDone, serial_tx_irq_enable} = '0;
    {enableWrite, enableWrData, pendWrite, pendWrData, condWrite} = '0;
    {condWrData, haltEnWrite, haltEnWrData, idleRequest, haltRequest} = '0;
    {sys_rst, reset_n_pin, shared_low_level_irq_pin} = 3'h7;
    void'($urandom(32'h8ded_af0e));
    cyc(4);
    sys_rst = 1'b0;
    cyc(1);
    chk(irq_enable_reg, ENAB_RST);
    chk(irq_pending_reg, PEND_RST);
    chk(vectorAddr, VEC_RST);
    for (i = 0; i < 4; i++) begin
      pol = 3'($urandom);
      slow = 1'($urandom);
      condWrData = pol;
      pulse(condWrite);
      ep = ~pol;
      cyc(6);
      wpend(8'h00);
      chk(irq_pending_reg[4:2], 3'h0);
      ep = pol;
      cyc(6);
      chk(irq_pending_reg[4:2], 3'h7);
      wpend(8'hff);
      chk(irq_pending_reg[4:2], 3'h7);
      wpend(8'h00);
      ep = ~pol;
      cyc(6);
      chk(irq_pending_reg[4:2], 3'h0);
      chk(acks.size(), 0);
    end
    wen(8'hfe);
    ep = pol;
    pulse(timerOverflow);
    cyc(6);
    wen(8'hff);
    for (i = 2; i < 5; i++) expAck(3'(i));
    expAck(SRC_TMR);
    chk(irq_pending_reg[5], 1'b1);
    wpend(8'hdf);
    chk(irq_pending_reg[5:2], 4'h0);
    wen(8'h00);
    {slow, pendWrData, pendWrite} = {1'b1, 8'h00, 1'b1};
    nonmaskable_pin = 1'b1;
    expAck(SRC_NMI);
    {nonmaskable_pin, pendWrite} = 2'b00;
    cyc(10);
    wen(8'h41);
    shared_low_level_irq_pin = 1'b0;
    expAck(SRC_SER);
    shared_low_level_irq_pin = 1'b1;
    cyc(10);
    serial_rx_irq_enable = 1'b1;
    serialRxDone = 1'b1;
    expAck(SRC_SER);
    {serialRxDone, serial_rx_irq_enable} = 2'b00;
    cyc(10);
    {serialTxDone, serial_tx_irq_enable} = 2'b11;
    expAck(SRC_SER);
    {serialTxDone, serial_tx_irq_enable} = 2'b00;
    cyc(10);
    wen(8'h81);
    high_level_irq_pin = 1'b1;
    expAck(SRC_HI);
    high_level_irq_pin = 1'b0;
    cyc(10);
    chk(stackPointer, SP_RST);
    wen(8'h80);
    pulse(plainReturn);
    chk(stackPointer, SP_RST - SP_STEP);
    chk(global_irq_enable, 1'b0);
    wen(8'h81);
    haltEnWrData = 1'b1;
    pulse(haltEnWrite);
    haltEnWrData = 1'b0;
    pulse(haltEnWrite);
    chk(haltEnable, 1'b1);
    pulse(haltRequest);
    ep = ~ep;
    high_level_irq_pin = 1'b1;
    cyc(8);
    chk(powerState, VIC_HALT);
    high_level_irq_pin = 1'b0;
    nonmaskable_pin = 1'b1;
    expAck(SRC_NMI);
    chk(powerState, VIC_RUN);
    nonmaskable_pin = 1'b0;
    cyc(10);
    pulse(idleRequest);
    chk(powerState, VIC_IDLE);
    pulse(freeTimerOverflow);
    cyc(2);
    chk(powerState, VIC_RUN);
    reset_n_pin = 1'b0;
    cyc(6);
    chk(coreReset, 1'b1);
    chk(vectorAddr, VEC_RST);
    chk(irq_enable_reg, 8'h00);
    reset_n_pin = 1'b1;
    cyc(8);
    stop_test();
  end
endmodule : vic_ctrl_tb_top
`default_nettype wire
